// ---- design/aacr_regs.sv ----
`timescale 1ns/100ps
module aacr_regs #(
	parameter logic [8:0] SI_REV_CODE   = 9'h0A5, // Arbitrary value
	parameter logic [8:0] DEV_ID_CS_LOW = 9'h0C1, // Arbitrary value
	parameter logic [8:0] DEV_ID_CS_HI  = 9'h0C2, // Arbitrary value
	parameter logic [8:0] CUST_ID_CODE  = 9'h0D7  // Arbitrary value
) (
	input  wire logic                clk_sys_i,
	input  wire logic                rst_n_i,
	input  wire logic                ctl_sclk_i,
	input  wire logic                ctl_sel_n_i,
	input  wire logic                ctl_sdi_i,
	output logic                     ctl_sdo_o,
	output logic                     ctl_sdo_oe_o,
	input  wire logic                chip_select_pin_i,
	input  wire logic [5:0]          left_gain_status_i,
	input  wire logic [5:0]          right_gain_status_i,
	input  wire logic [8:0]          abs_peak_i,
	input  wire logic [8:0]          p2p_peak_i,
	input  wire logic                over_limit_i,
	input  wire logic                clock_error_i,
	input  wire logic                notch_enable_i,
	input  wire logic                notch_settled_i,
	input  wire logic                pll_lock_raw_i,
	output aacr_pkg::aacr_ctl_t      ctl_o,
	output logic [8:0]               training_peak_o,
	output logic [8:0]               gate_peak_o,
	output logic [8:0]               peak_value_o,
	output logic                     fast_dec_o,
	output logic                     filter_flush_o,
	output logic                     notch_out_valid_o,
	output logic                     pll_lock_o,
	output logic                     address_select_o
);

	// Three-stage synchronisers for pins from outside the domain
	logic [2:0] sclk_s_r, sel_s_r, sdi_s_r, cs_s_r, lock_s_r;
	logic       sclk_f_r, sel_f_r, sdi_f_r, cs_f_r, lock_f_r;
	logic       sclk_f_nxt, sel_f_nxt, sdi_f_nxt, cs_f_nxt, lock_f_nxt;

	always_comb
	begin
		// A level counts once stages two and three agree
		sclk_f_nxt = (sclk_s_r[1] == sclk_s_r[2]) ? sclk_s_r[2] : sclk_f_r;
		sel_f_nxt  = (sel_s_r[1] == sel_s_r[2]) ? sel_s_r[2] : sel_f_r;
		sdi_f_nxt  = (sdi_s_r[1] == sdi_s_r[2]) ? sdi_s_r[2] : sdi_f_r;
		cs_f_nxt   = (cs_s_r[1] == cs_s_r[2]) ? cs_s_r[2] : cs_f_r;
		lock_f_nxt = (lock_s_r[1] == lock_s_r[2]) ? lock_s_r[2] : lock_f_r;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sclk_s_r <= 3'h0;
			sel_s_r  <= 3'h7;
			sdi_s_r  <= 3'h0;
			cs_s_r   <= 3'h0;
			lock_s_r <= 3'h0;
			sclk_f_r <= 1'b0;
			sel_f_r  <= 1'b1;
			sdi_f_r  <= 1'b0;
			cs_f_r   <= 1'b0;
			lock_f_r <= 1'b0;
		end
		else
		begin
			sclk_s_r <= {sclk_s_r[1:0], ctl_sclk_i};
			sel_s_r  <= {sel_s_r[1:0], ctl_sel_n_i};
			sdi_s_r  <= {sdi_s_r[1:0], ctl_sdi_i};
			cs_s_r   <= {cs_s_r[1:0], chip_select_pin_i};
			lock_s_r <= {lock_s_r[1:0], pll_lock_raw_i};
			sclk_f_r <= sclk_f_nxt;
			sel_f_r  <= sel_f_nxt;
			sdi_f_r  <= sdi_f_nxt;
			cs_f_r   <= cs_f_nxt;
			lock_f_r <= lock_f_nxt;
		end
	end

	// Edge events on the filtered link levels
	logic sclk_rise, sclk_fall, frame_start, frame_end;
	assign sclk_rise   = sclk_f_nxt & ~sclk_f_r;
	assign sclk_fall   = ~sclk_f_nxt & sclk_f_r;
	assign frame_start = ~sel_f_nxt & sel_f_r;
	assign frame_end   = sel_f_nxt & ~sel_f_r;

	// Register storage
	logic [8:0] lvl_r, pk_r, cnv_r, port_r, tie_r;
	logic [8:0] lvl_nxt, pk_nxt, cnv_nxt, port_nxt, tie_nxt;
	logic       id_strap_r, id_strap_nxt;
	logic [3:0] strap_sh_r, strap_sh_nxt;
	logic       id_frame_r, id_frame_nxt;
	logic       id_level;

	// Frame engine state
	aacr_pkg::aacr_state_t st_r, st_nxt;
	logic [4:0]  cnt_r, cnt_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic [6:0]  addr_r, addr_nxt;
	logic        rd_r, rd_nxt;
	logic [8:0]  out_r, out_nxt;
	logic        oe_r, oe_nxt;
	logic        wr_fire;
	logic [8:0]  wr_data;
	logic        clr_pulse;

	// Read word for an address; undefined bits and addresses give zero
	function automatic logic [8:0] rd_word(input logic [6:0] a);
		logic [8:0] w;
		w = 9'h000;
		case (a)
			aacr_pkg::OFS_SI_REV:  w = SI_REV_CODE;
			aacr_pkg::OFS_DEV_ID:  w = id_level ? DEV_ID_CS_HI : DEV_ID_CS_LOW;
			aacr_pkg::OFS_CUST_ID: w = CUST_ID_CODE;
			aacr_pkg::OFS_LVL_OPT: w = lvl_r | {3'h0, left_gain_status_i};
			aacr_pkg::OFS_PK_HOLD: w = pk_r | {3'h0, right_gain_status_i};
			aacr_pkg::OFS_CNV_EQ:  w = cnv_r;
			aacr_pkg::OFS_PORT:    w = port_r;
			aacr_pkg::OFS_TIEOFF:  w = tie_r;
			default:               w = 9'h000;
		endcase
		return w;
	endfunction : rd_word

	// Serial frame: seven address bits, read flag, nine data bits, MSB first
	always_comb
	begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		sh_nxt   = sh_r;
		addr_nxt = addr_r;
		rd_nxt   = rd_r;
		out_nxt  = out_r;
		oe_nxt   = oe_r;
		wr_fire  = 1'b0;
		wr_data  = {sh_r[7:0], sdi_f_r};
		case (st_r)
			aacr_pkg::ST_IDLE:
			begin
				oe_nxt = 1'b0;
				if (frame_start)
				begin
					st_nxt  = aacr_pkg::ST_HDR;
					cnt_nxt = 5'h00;
				end
			end
			aacr_pkg::ST_HDR:
			begin
				if (sclk_rise)
				begin
					sh_nxt  = {sh_r[14:0], sdi_f_r};
					cnt_nxt = cnt_r + 5'h01;
					if (cnt_r == aacr_pkg::CNT_HDR - 5'h01)
					begin
						addr_nxt = sh_r[6:0];
						rd_nxt   = sdi_f_r;
						st_nxt   = aacr_pkg::ST_DATA;
					end
				end
			end
			aacr_pkg::ST_DATA:
			begin
				if (sclk_rise && cnt_r != aacr_pkg::CNT_FULL)
				begin
					sh_nxt  = {sh_r[14:0], sdi_f_r};
					cnt_nxt = cnt_r + 5'h01;
					// Last data bit completes a write
					wr_fire = ~rd_r && (cnt_r == aacr_pkg::CNT_LAST);
				end
				// Read data launched on falling edges, sampled on rising
				if (sclk_fall && rd_r)
				begin
					if (cnt_r == aacr_pkg::CNT_HDR)
					begin
						out_nxt = rd_word(addr_r);
						oe_nxt  = 1'b1;
					end
					else if (cnt_r > aacr_pkg::CNT_HDR)
						out_nxt = {out_r[7:0], 1'b0};
				end
			end
			default:
				st_nxt = aacr_pkg::ST_IDLE;
		endcase
		// Deselect aborts any frame; a partial write is dropped
		if (frame_end)
		begin
			st_nxt = aacr_pkg::ST_IDLE;
			oe_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r   <= aacr_pkg::ST_IDLE;
			cnt_r  <= 5'h00;
			sh_r   <= 16'h0000;
			addr_r <= 7'h00;
			rd_r   <= 1'b0;
			out_r  <= 9'h000;
			oe_r   <= 1'b0;
		end
		else
		begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			sh_r   <= sh_nxt;
			addr_r <= addr_nxt;
			rd_r   <= rd_nxt;
			out_r  <= out_nxt;
			oe_r   <= oe_nxt;
		end
	end

	assign ctl_sdo_o    = out_r[8];
	assign ctl_sdo_oe_o = oe_r;

	// Register writes; masks keep undefined bits at zero
	always_comb
	begin
		lvl_nxt   = lvl_r;
		pk_nxt    = pk_r;
		cnv_nxt   = cnv_r;
		port_nxt  = port_r;
		tie_nxt   = tie_r;
		clr_pulse = 1'b0;
		if (wr_fire)
		begin
			case (addr_r)
				aacr_pkg::OFS_LVL_OPT: lvl_nxt = wr_data & aacr_pkg::MASK_LVL_OPT;
				aacr_pkg::OFS_PK_HOLD:
				begin
					pk_nxt = wr_data & aacr_pkg::MASK_PK_HOLD;
					// Clear bit is a strobe, never stored
					clr_pulse = wr_data[aacr_pkg::BIT_PEAK_CLEAR];
				end
				aacr_pkg::OFS_CNV_EQ:  cnv_nxt  = wr_data & aacr_pkg::MASK_CNV_EQ;
				aacr_pkg::OFS_PORT:    port_nxt = wr_data & aacr_pkg::MASK_PORT;
				aacr_pkg::OFS_TIEOFF:  tie_nxt  = wr_data & aacr_pkg::MASK_TIEOFF;
				default:               lvl_nxt  = lvl_r;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lvl_r  <= aacr_pkg::RST_LVL_OPT;
			pk_r   <= aacr_pkg::RST_PK_HOLD;
			cnv_r  <= aacr_pkg::RST_CNV_EQ;
			port_r <= aacr_pkg::RST_PORT;
			tie_r  <= aacr_pkg::RST_TIEOFF;
		end
		else
		begin
			lvl_r  <= lvl_nxt;
			pk_r   <= pk_nxt;
			cnv_r  <= cnv_nxt;
			port_r <= port_nxt;
			tie_r  <= tie_nxt;
		end
	end

	// Chip-select level: strap caught once after reset, or per frame
	always_comb
	begin
		// Strap waits four edges so it sees the pin, not the synchroniser's reset value
		strap_sh_nxt = {strap_sh_r[2:0], 1'b1};
		id_strap_nxt = strap_sh_r[3] ? id_strap_r : cs_f_nxt;
		id_frame_nxt = frame_start ? cs_f_r : id_frame_r;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			strap_sh_r   <= 4'h0;
			id_strap_r   <= 1'b0;
			id_frame_r   <= 1'b0;
		end
		else
		begin
			strap_sh_r   <= strap_sh_nxt;
			id_strap_r   <= id_strap_nxt;
			id_frame_r   <= id_frame_nxt;
		end
	end

	assign id_level         = ctl_o.address_latch_mode ? id_strap_r : id_frame_r;
	assign address_select_o = id_level;

	// Control fields out of the register words
	always_comb
	begin
		ctl_o.target_range_select     = lvl_r[aacr_pkg::BIT_TABLE_SEL];
		ctl_o.training_peak_source    = lvl_r[aacr_pkg::BIT_TRAIN_SRC];
		ctl_o.gate_peak_source        = lvl_r[aacr_pkg::BIT_GATE_SRC];
		ctl_o.fast_decrement_disable  = pk_r[aacr_pkg::BIT_FAST_DIS];
		ctl_o.peak_hold               = pk_r[aacr_pkg::BIT_PEAK_HOLD];
		ctl_o.converter_capture_phase = {cnv_r[aacr_pkg::BIT_CAPT_EDGE],
		                                 cnv_r[aacr_pkg::BIT_CLK_PHASE]};
		ctl_o.mic_channel_swap        = cnv_r[aacr_pkg::BIT_MIC_SWAP];
		ctl_o.right_dmic_enable       = cnv_r[aacr_pkg::BIT_DMIC_R];
		ctl_o.left_dmic_enable        = cnv_r[aacr_pkg::BIT_DMIC_L];
		ctl_o.dmic_fast_slew          = cnv_r[aacr_pkg::BIT_DMIC_SLEW];
		ctl_o.level_ctl_link          = cnv_r[aacr_pkg::BIT_LINK];
		ctl_o.equalizer_enable        = cnv_r[aacr_pkg::BIT_EQ_EN];
		ctl_o.sinc_align_bypass       = cnv_r[aacr_pkg::BIT_ALIGN_BYP];
		ctl_o.force_four_wire         = port_r[aacr_pkg::BIT_FORCE_4W];
		ctl_o.flush_on_error          = port_r[aacr_pkg::BIT_FLUSH];
		ctl_o.address_latch_mode      = port_r[aacr_pkg::BIT_ADDR_LATCH];
		ctl_o.notch_settle_bypass     = port_r[aacr_pkg::BIT_NOTCH_BYP];
		ctl_o.lock_force_high         = port_r[aacr_pkg::BIT_LOCK_FORCE];
		ctl_o.midrail_manual_control  = tie_r[aacr_pkg::BIT_MIDRAIL];
	end

	// Peak selection and the stored peak
	logic [8:0] train_nxt, gate_nxt, peak_r, peak_nxt;
	logic [8:0] train_r, gate_r;

	always_comb
	begin
		train_nxt = ctl_o.training_peak_source ? p2p_peak_i : abs_peak_i;
		gate_nxt  = ctl_o.gate_peak_source ? abs_peak_i : p2p_peak_i;
		// Hold keeps the largest peak seen; clear only acts while holding
		if (ctl_o.peak_hold && clr_pulse)
			peak_nxt = 9'h000;
		else if (ctl_o.peak_hold)
			peak_nxt = (train_nxt > peak_r) ? train_nxt : peak_r;
		else
			peak_nxt = train_nxt;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			train_r <= 9'h000;
			gate_r  <= 9'h000;
			peak_r  <= 9'h000;
		end
		else
		begin
			train_r <= train_nxt;
			gate_r  <= gate_nxt;
			peak_r  <= peak_nxt;
		end
	end

	assign training_peak_o = train_r;
	assign gate_peak_o     = gate_r;
	assign peak_value_o    = peak_r;

	// Status qualifiers; handshake-like, left combinational
	assign fast_dec_o        = over_limit_i & ~ctl_o.fast_decrement_disable;
	assign filter_flush_o    = clock_error_i & ctl_o.flush_on_error;
	assign notch_out_valid_o = notch_enable_i
	                           & (notch_settled_i | ctl_o.notch_settle_bypass);
	assign pll_lock_o        = lock_f_r | ctl_o.lock_force_high;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_read_load(logic [6:0] a);
		st_r == aacr_pkg::ST_DATA && sclk_fall && rd_r && cnt_r == aacr_pkg::CNT_HDR
			&& addr_r == a;
	endsequence

	a_si_rev_read: assert property (s_read_load(aacr_pkg::OFS_SI_REV) |=>
		out_r == SI_REV_CODE && oe_r) else $error("silicon revision read wrong");
	a_dev_id_read: assert property (s_read_load(aacr_pkg::OFS_DEV_ID) |=>
		out_r == ($past(id_level) ? DEV_ID_CS_HI : DEV_ID_CS_LOW))
		else $error("device identity read wrong");
	a_cust_id_read: assert property (s_read_load(aacr_pkg::OFS_CUST_ID) |=>
		out_r == CUST_ID_CODE) else $error("custom identity read wrong");
	a_gain_readback: assert property (s_read_load(aacr_pkg::OFS_PK_HOLD) |=>
		out_r[5:0] == $past(right_gain_status_i)) else $error("gain readback wrong");
	a_fast_dec_gate: assert property (ctl_o.fast_decrement_disable |-> !fast_dec_o)
		else $error("fast decrement not disabled");
	a_peak_hold_keep: assert property (ctl_o.peak_hold && !clr_pulse |=>
		peak_r >= $past(peak_r)) else $error("held peak dropped");
	a_peak_clear_zero: assert property (ctl_o.peak_hold && clr_pulse |=>
		peak_r == 9'h000) else $error("peak not cleared");
	a_undef_bits_zero: assert property ((lvl_r & ~aacr_pkg::MASK_LVL_OPT) == 9'h000
		&& (port_r & ~aacr_pkg::MASK_PORT) == 9'h000) else $error("undefined bit set");
	a_lock_forced: assert property (ctl_o.lock_force_high |-> pll_lock_o)
		else $error("lock not forced");
	a_notch_wait: assert property (notch_enable_i && !notch_settled_i
		&& !ctl_o.notch_settle_bypass |-> !notch_out_valid_o) else $error("notch early");

endmodule : aacr_regs

// ---- design/aacr_pkg.sv ----
// Contract
// - Read-only 9-bit silicon revision register returns a fixed code.
// - Device identity register returns one of two codes per chip-select level.
// - Read-only 9-bit custom identity register returns a fixed code.
// - Table-select bit picks level target range, low or high table.
// - Training uses absolute peak when clear, peak-to-peak when set.
// - Noise gate uses peak-to-peak when clear, absolute peak when set.
// - Left and right level-control gains read back as 6-bit fields.
// - Fast gain decrement above 87.5% runs while its disable bit is clear.
// - Peak hold keeps the stored peak until a clear is written.
// - Writing one to peak clear while holding zeroes the stored peak.
// - Two test bits pick converter capture edge and converter clock phase.
// - Swap bit reverses microphone to channel mapping when set.
// - Separate bits enable the right and left digital microphones.
// - Link bit, set at reset, shares one gain between both channels.
// - Equalizer bit, set at reset, enables equalizer; clear bypasses it.
// - Alignment delay on sinc outputs unless the bypass bit is set.
// - Force bit selects four-wire control port regardless of mode pin.
// - Flush bit clears filter memory whenever a clocking error occurs.
// - Address follows chip-select per transaction, or its level at reset.
// - Notch output waits for settling unless the bypass bit is set.
// - Lock-bypass bit forces the lock indication high.
package aacr_pkg;

	// Register offsets (7-bit control-port addresses)
	localparam logic [6:0] OFS_SI_REV  = 7'h5E;
	localparam logic [6:0] OFS_DEV_ID  = 7'h5F;
	localparam logic [6:0] OFS_CUST_ID = 7'h60;
	localparam logic [6:0] OFS_LVL_OPT = 7'h66;
	localparam logic [6:0] OFS_PK_HOLD = 7'h67;
	localparam logic [6:0] OFS_CNV_EQ  = 7'h68;
	localparam logic [6:0] OFS_PORT    = 7'h69;
	localparam logic [6:0] OFS_TIEOFF  = 7'h6A;

	// Writable bit masks; other bits read zero, except the gain status in bits 5:0 of OFS_LVL_OPT and OFS_PK_HOLD
	localparam logic [8:0] MASK_LVL_OPT = 9'h1C0;
	localparam logic [8:0] MASK_PK_HOLD = 9'h140;
	localparam logic [8:0] MASK_CNV_EQ  = 9'h1FF;
	localparam logic [8:0] MASK_PORT    = 9'h13A;
	localparam logic [8:0] MASK_TIEOFF  = 9'h100;

	// Reset values
	localparam logic [8:0] RST_LVL_OPT = 9'h000;
	localparam logic [8:0] RST_PK_HOLD = 9'h000;
	localparam logic [8:0] RST_CNV_EQ  = 9'h006;
	localparam logic [8:0] RST_PORT    = 9'h000;
	localparam logic [8:0] RST_TIEOFF  = 9'h000;

	// Field positions
	localparam int BIT_TABLE_SEL   = 8;
	localparam int BIT_TRAIN_SRC   = 7;
	localparam int BIT_GATE_SRC    = 6;
	localparam int BIT_FAST_DIS    = 8;
	localparam int BIT_PEAK_CLEAR  = 7;
	localparam int BIT_PEAK_HOLD   = 6;
	localparam int BIT_CAPT_EDGE   = 8;
	localparam int BIT_CLK_PHASE   = 7;
	localparam int BIT_MIC_SWAP    = 6;
	localparam int BIT_DMIC_R      = 5;
	localparam int BIT_DMIC_L      = 4;
	localparam int BIT_DMIC_SLEW   = 3;
	localparam int BIT_LINK        = 2;
	localparam int BIT_EQ_EN       = 1;
	localparam int BIT_ALIGN_BYP   = 0;
	localparam int BIT_FORCE_4W    = 8;
	localparam int BIT_FLUSH       = 5;
	localparam int BIT_ADDR_LATCH  = 4;
	localparam int BIT_NOTCH_BYP   = 3;
	localparam int BIT_LOCK_FORCE  = 1;
	localparam int BIT_MIDRAIL     = 8;

	// Serial frame: address, read flag, data
	localparam int ADDR_BITS  = 7;
	localparam int DATA_BITS  = 9;
	localparam int FRAME_BITS = 17;
	localparam logic [4:0] CNT_HDR  = 5'h08;
	localparam logic [4:0] CNT_LAST = 5'h10;
	localparam logic [4:0] CNT_FULL = 5'h11;

	// Decoded control outputs
	typedef struct packed {
		logic       target_range_select;
		logic       training_peak_source;
		logic       gate_peak_source;
		logic       fast_decrement_disable;
		logic       peak_hold;
		logic [1:0] converter_capture_phase;
		logic       mic_channel_swap;
		logic       right_dmic_enable;
		logic       left_dmic_enable;
		logic       dmic_fast_slew;
		logic       level_ctl_link;
		logic       equalizer_enable;
		logic       sinc_align_bypass;
		logic       force_four_wire;
		logic       flush_on_error;
		logic       address_latch_mode;
		logic       notch_settle_bypass;
		logic       lock_force_high;
		logic       midrail_manual_control;
	} aacr_ctl_t;

	// Frame phases
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HDR  = 2'b01,
		ST_DATA = 2'b10
	} aacr_state_t;

endpackage : aacr_pkg

// ---- testbench/aacr_host.sv ----
`timescale 1ns/100ps
module aacr_host (
	input  wire logic clk_sys_i,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i,
	output logic      sclk_o,
	output logic      sel_n_o,
	output logic      sdi_o
);
	// Clock parked low, frame deselected outside frames
	initial
	begin
		sclk_o = 1'b0;
		sel_n_o = 1'b1;
		sdi_o = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : wait_clk

	// One frame, MSB first; each phase holds far longer than the sync delay
	task automatic xfer(input logic [6:0] addr, input logic rd, input logic [8:0] wdata,
		output logic [8:0] rdata, output logic oe_seen);
		logic [16:0] frame;
		frame = {addr, rd, wdata};
		rdata = 9'h000;
		oe_seen = 1'b1;
		sel_n_o = 1'b0;
		wait_clk(4);
		for (int i = 16; i >= 0; i--)
		begin
			sdi_o = frame[i];
			wait_clk(12);
			if (i <= 8)
			begin
				rdata[i] = sdo_i;
				oe_seen = oe_seen & sdo_oe_i;
			end
			sclk_o = 1'b1;
			wait_clk(13);
			sclk_o = 1'b0;
		end
		wait_clk(12);
		sel_n_o = 1'b1;
		// Released line must not keep showing the last bit
		sdi_o = ~sdi_o;
		wait_clk(8);
	endtask : xfer
endmodule : aacr_host

// ---- testbench/test_audio_adc_aux_control_regs.sv ----
`timescale 1ns/100ps
module test_audio_adc_aux_control_regs;
	localparam logic [8:0] REV = 9'h111; // Arbitrary value
	localparam logic [8:0] IDL = 9'h122; // Arbitrary value
	localparam logic [8:0] IDH = 9'h133; // Arbitrary value
	localparam logic [8:0] CID = 9'h144; // Arbitrary value
	logic                clk, rst_n, sclk, sel_n, sdi, sdo, sdo_oe, cs_pin;
	logic [5:0]          lgain, rgain;
	logic [8:0]          abs_pk, p2p_pk, train_pk, gate_pk, pk_val;
	logic                over_lim, clk_err, notch_en, notch_set, lock_raw;
	logic                fast_dec, flush, notch_ok, lock, addr_sel;
	aacr_pkg::aacr_ctl_t ctl;
	int                  fails, check_count, cycles;

	aacr_regs #(.SI_REV_CODE(REV), .DEV_ID_CS_LOW(IDL), .DEV_ID_CS_HI(IDH),
		.CUST_ID_CODE(CID)) DUT (
		.clk_sys_i(clk), .rst_n_i(rst_n), .ctl_sclk_i(sclk), .ctl_sel_n_i(sel_n),
		.ctl_sdi_i(sdi), .ctl_sdo_o(sdo), .ctl_sdo_oe_o(sdo_oe), .chip_select_pin_i(cs_pin),
		.left_gain_status_i(lgain), .right_gain_status_i(rgain), .abs_peak_i(abs_pk),
		.p2p_peak_i(p2p_pk), .over_limit_i(over_lim), .clock_error_i(clk_err),
		.notch_enable_i(notch_en), .notch_settled_i(notch_set), .pll_lock_raw_i(lock_raw),
		.ctl_o(ctl), .training_peak_o(train_pk), .gate_peak_o(gate_pk), .peak_value_o(pk_val),
		.fast_dec_o(fast_dec), .filter_flush_o(flush), .notch_out_valid_o(notch_ok),
		.pll_lock_o(lock), .address_select_o(addr_sel));

	aacr_host host (.clk_sys_i(clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sclk_o(sclk),
		.sel_n_o(sel_n), .sdi_o(sdi));

	// 200 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Hang guard: whole run needs roughly 17k cycles
	initial
	begin
		cycles = 0;
		forever
		begin
			@(posedge clk);
			cycles++;
			if (cycles == 60000)
			begin
				fails++;
				summarize();
			end
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic chk9(input logic [8:0] got, input logic [8:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk9

	task automatic chk1(input logic got, input logic exp, input string what);
		chk9({8'h00, got}, {8'h00, exp}, what);
	endtask : chk1

	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		logic [8:0] q;
		logic       oe;
		host.xfer(a, 1'b0, d, q, oe);
	endtask : wr

	// Read a register and check both data and the drive enable
	task automatic rd_chk(input logic [6:0] a, input logic [8:0] exp);
		logic [8:0] q;
		logic       oe;
		host.xfer(a, 1'b1, 9'h000, q, oe);
		chk9(q, exp, $sformatf("read %h", a));
		chk1(oe, 1'b1, "read drive enable");
	endtask : rd_chk

	task automatic test_ids();
		rd_chk(aacr_pkg::OFS_SI_REV, REV);
		wr(aacr_pkg::OFS_SI_REV, 9'h000);
		rd_chk(aacr_pkg::OFS_SI_REV, REV);
		rd_chk(aacr_pkg::OFS_DEV_ID, IDL);
		cs_pin = 1'b1;
		step(8);
		rd_chk(aacr_pkg::OFS_DEV_ID, IDH);
		chk1(addr_sel, 1'b1, "per-frame address select");
		wr(aacr_pkg::OFS_CUST_ID, 9'h000);
		rd_chk(aacr_pkg::OFS_CUST_ID, CID);
		rd_chk(7'h61, 9'h000);
		$display("test_ids done");
	endtask : test_ids

	task automatic test_reset_vals();
		chk1(ctl.level_ctl_link, 1'b1, "link at reset");
		chk1(ctl.equalizer_enable, 1'b1, "eq at reset");
		rd_chk(aacr_pkg::OFS_LVL_OPT, 9'h02A);
		rd_chk(aacr_pkg::OFS_PK_HOLD, 9'h015);
		rd_chk(aacr_pkg::OFS_CNV_EQ, 9'h006);
		rd_chk(aacr_pkg::OFS_PORT, 9'h000);
		rd_chk(aacr_pkg::OFS_TIEOFF, 9'h000);
		$display("test_reset_vals done");
	endtask : test_reset_vals

	task automatic test_level();
		wr(aacr_pkg::OFS_LVL_OPT, 9'h1FF);
		rd_chk(aacr_pkg::OFS_LVL_OPT, 9'h1EA);
		chk1(ctl.target_range_select, 1'b1, "high table");
		chk9(train_pk, p2p_pk, "training uses p2p");
		chk9(gate_pk, abs_pk, "gate uses abs");
		wr(aacr_pkg::OFS_LVL_OPT, 9'h000);
		chk1(ctl.target_range_select, 1'b0, "low table");
		chk9(train_pk, abs_pk, "training uses abs");
		chk9(gate_pk, p2p_pk, "gate uses p2p");
		$display("test_level done");
	endtask : test_level

	task automatic test_peak();
		over_lim = 1'b1;
		step(2);
		chk1(fast_dec, 1'b1, "fast decrement on");
		wr(aacr_pkg::OFS_PK_HOLD, 9'h100);
		chk1(fast_dec, 1'b0, "fast decrement off");
		wr(aacr_pkg::OFS_PK_HOLD, 9'h040);
		abs_pk = 9'h1F0;
		step(4);
		abs_pk = 9'h010;
		step(4);
		chk9(pk_val, 9'h1F0, "held peak");
		rd_chk(aacr_pkg::OFS_PK_HOLD, 9'h055);
		abs_pk = 9'h000;
		wr(aacr_pkg::OFS_PK_HOLD, 9'h0C0);
		chk9(pk_val, 9'h000, "peak cleared");
		rd_chk(aacr_pkg::OFS_PK_HOLD, 9'h055);
		// Host drops hold again once diagnostics are over
		wr(aacr_pkg::OFS_PK_HOLD, 9'h000);
		abs_pk = 9'h0F0;
		step(4);
		chk9(pk_val, 9'h0F0, "peak follows");
		$display("test_peak done");
	endtask : test_peak

	task automatic test_cnv();
		logic [8:0] vals [4];
		vals = '{9'h1F9, 9'h026, 9'h150, 9'h0A1};
		foreach (vals[k])
		begin
			wr(aacr_pkg::OFS_CNV_EQ, vals[k]);
			chk9({ctl.converter_capture_phase, ctl.mic_channel_swap, ctl.right_dmic_enable,
				ctl.left_dmic_enable, ctl.dmic_fast_slew, ctl.level_ctl_link,
				ctl.equalizer_enable, ctl.sinc_align_bypass}, vals[k], "converter fields");
			rd_chk(aacr_pkg::OFS_CNV_EQ, vals[k]);
		end
		$display("test_cnv done");
	endtask : test_cnv

	task automatic test_port();
		clk_err = 1'b1;
		notch_en = 1'b1;
		wr(aacr_pkg::OFS_PORT, 9'h1FF);
		rd_chk(aacr_pkg::OFS_PORT, 9'h13A);
		chk1(ctl.force_four_wire, 1'b1, "force four wire");
		chk1(lock, 1'b1, "lock forced");
		chk1(flush, 1'b1, "flush on error");
		chk1(notch_ok, 1'b1, "notch bypass");
		chk1(addr_sel, 1'b0, "strap address");
		wr(aacr_pkg::OFS_PORT, 9'h000);
		rd_chk(aacr_pkg::OFS_PORT, 9'h000);
		chk1(lock, 1'b0, "lock normal");
		chk1(flush, 1'b0, "no flush");
		chk1(notch_ok, 1'b0, "notch waits");
		chk1(addr_sel, 1'b1, "per-frame address");
		notch_set = 1'b1;
		lock_raw = 1'b1;
		step(6);
		chk1(notch_ok, 1'b1, "notch settled");
		chk1(lock, 1'b1, "raw lock");
		wr(aacr_pkg::OFS_TIEOFF, 9'h1FF);
		rd_chk(aacr_pkg::OFS_TIEOFF, 9'h100);
		chk1(ctl.midrail_manual_control, 1'b1, "midrail manual");
		$display("test_port done");
	endtask : test_port

	// Mid-run reset with the pin high; strap mode keeps the level seen at reset
	task automatic test_strap();
		cs_pin = 1'b1;
		rst_n = 1'b0;
		step(3);
		rst_n = 1'b1;
		step(4);
		chk1(ctl.equalizer_enable, 1'b1, "eq after reset");
		wr(aacr_pkg::OFS_PORT, 9'h010);
		cs_pin = 1'b0;
		step(8);
		chk1(addr_sel, 1'b1, "strap keeps pin level");
		rd_chk(aacr_pkg::OFS_DEV_ID, IDH);
		$display("test_strap done");
	endtask : test_strap

	task automatic summarize();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// Main sequence
	initial
	begin
		fails = 0;
		check_count = 0;
		rst_n = 1'b0;
		cs_pin = 1'b0;
		lgain = 6'h2A;
		rgain = 6'h15;
		abs_pk = 9'h0F0;
		p2p_pk = 9'h155;
		over_lim = 1'b0;
		clk_err = 1'b0;
		notch_en = 1'b0;
		notch_set = 1'b0;
		lock_raw = 1'b0;
		step(3);
		rst_n = 1'b1;
		step(4);
		test_reset_vals();
		test_ids();
		test_level();
		test_peak();
		test_cnv();
		test_port();
		test_strap();
		summarize();
	end
endmodule : test_audio_adc_aux_control_regs
